/* design/thermal_throttle_map.svh */
// Register offsets, reset values, band thresholds and timing counts of the
// thermal throttle monitor. Definitions only; included by the design and bench.
//
// Operation
// - Measure per-channel throttle time, 1/256 steps
// - Interval end copies count into current reading
// - Average becomes old average plus previous reading, halved
// - Writing either current reading restarts both channels
// - Half-step bias: zero only if never asserted
// - Reading n covers (n-1)/256 to n/256; 255 also covers up to full
// - Full-throttle bit when never released
// - Upper band: reading 193 or more, not full
// - Band bits 129-192, 65-128, 33-64, 1-32
// - Nonzero bit and strict over-limit bit
// - Two independent channels with own registers
// - Sleep stops measurement, clears current, holds average
// - First reading after wake loads both registers
// - Short mode mirrors external assertion onto other pin
// - Regulator hot drives matching pin within 10us
// - Short mode: either hot drives both pins
// - Hot response off in sleep or by control
// - Override PWM on chosen pin, both if shorted
`ifndef THERMAL_THROTTLE_MAP_SVH
`define THERMAL_THROTTLE_MAP_SVH

`define TTM_ADDR_W        4
`define TTM_OFS_CTRL      4'h0
`define TTM_OFS_INTERVAL  4'h1
`define TTM_OFS_LIMIT1    4'h2
`define TTM_OFS_LIMIT2    4'h3
`define TTM_OFS_OVERRIDE  4'h4
`define TTM_OFS_CUR1      4'h5
`define TTM_OFS_CUR2      4'h6
`define TTM_OFS_AVG1      4'h7
`define TTM_OFS_AVG2      4'h8
`define TTM_OFS_STAT1     4'h9
`define TTM_OFS_STAT2     4'hA

`define TTM_RST_CTRL      8'h00
`define TTM_RST_INTERVAL  8'h00
`define TTM_RST_LIMIT     8'hFF
`define TTM_RST_OVERRIDE  8'h00

`define TTM_SLEEP_RUN     2'h0

`define TTM_BAND_UPPER    8'hC1
`define TTM_BAND_HIGH     8'h81
`define TTM_BAND_MID      8'h41
`define TTM_BAND_LOW      8'h21

`define TTM_SLOT_BASE     200
`define TTM_HOT_RESP_US   10
`define TTM_CLK_MHZ       200
`define TTM_HOT_RESP_CYC  (`TTM_HOT_RESP_US * `TTM_CLK_MHZ)
`define TTM_PWM_PRESCALE  8'hC7
`define TTM_OWN_HIST      3

`endif

/* design/thermal_throttle_monitor.sv */
// Two-channel thermal throttle monitor with throttle pin drive.
// Assumes one 200 MHz clock, a synchronous reset, and pins and regulator hot
// inputs that arrive asynchronously; pins are open-drain with outside pull-ups.
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "thermal_throttle_map.svh"

module thermal_throttle_monitor #(
	parameter int SLOT_BASE = `TTM_SLOT_BASE
) (
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire logic                   ce_i,
	input  wire logic [`TTM_ADDR_W-1:0] addr_i,
	input  wire logic [7:0]             wdata_i,
	input  wire logic                   wr_i,
	input  wire logic                   rd_i,
	output logic      [7:0]             rdata_o,
	input  wire logic                   cpu1_throttle_n_i,
	output logic                        cpu1_throttle_n_o,
	output logic                        cpu1_throttle_n_oe_o,
	input  wire logic                   cpu2_throttle_n_i,
	output logic                        cpu2_throttle_n_o,
	output logic                        cpu2_throttle_n_oe_o,
	input  wire logic [1:0]             regulator_hot_n_i
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic [1:0]                     pin_s1, pin_s2, hot_s1, hot_s2;
	thermal_throttle_pkg::ctrl_t     ctrl, next_ctrl;
	thermal_throttle_pkg::override_t ovr, next_ovr;
	thermal_throttle_pkg::mon_state_t state, next_state;
	logic [7:0]  interval, next_interval;
	logic [7:0]  limit [2], next_limit [2];
	logic [7:0]  cur [2], next_cur [2];
	logic [7:0]  avg [2], next_avg [2];
	logic [7:0]  stat [2], next_stat [2];
	logic [23:0] sub [2], next_sub [2];
	logic [8:0]  q [2], next_q [2];
	logic [1:0]  full, next_full;
	logic        first, next_first;
	logic [23:0] pos, next_pos;
	logic [7:0]  slot, next_slot;
	logic [7:0]  pwm_pre, next_pwm_pre;
	logic [3:0]  pwm_ph, next_pwm_ph;
	logic [`TTM_OWN_HIST-1:0] hist [2], next_hist [2];
	logic [1:0]  oe, next_oe;
	logic [7:0]  next_rdata;
	logic [23:0] slot_len;
	logic [1:0]  asserted, hot, ext, ovr_on;
	logic        sleeping, restart, end_evt;

	function automatic logic [7:0] band(input logic [7:0] r, input logic f,
		input logic [7:0] lim);
		logic [7:0] b;
		b = 8'h00;
		b[0] = f;
		b[1] = (r >= `TTM_BAND_UPPER) && !f;
		b[2] = (r >= `TTM_BAND_HIGH) && (r < `TTM_BAND_UPPER);
		b[3] = (r >= `TTM_BAND_MID) && (r < `TTM_BAND_HIGH);
		b[4] = (r >= `TTM_BAND_LOW) && (r < `TTM_BAND_MID);
		b[5] = (r != 8'h00) && (r < `TTM_BAND_LOW);
		b[6] = (r != 8'h00);
		b[7] = (r > lim);
		return b;
	endfunction : band

	// ---------------------------------------------------------------
	// Input synchronisers
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pin_s1 <= 2'h3;
			pin_s2 <= 2'h3;
			hot_s1 <= 2'h3;
			hot_s2 <= 2'h3;
		end
		else if (ce_i)
		begin
			pin_s1 <= {cpu2_throttle_n_i, cpu1_throttle_n_i};
			pin_s2 <= pin_s1;
			hot_s1 <= regulator_hot_n_i;
			hot_s2 <= hot_s1;
		end
	end

	// One slot is 1/256 of the interval, so the interval spans 256 slots.
	// interval slot length
	assign slot_len = 24'(({16'h0000, interval} + 24'h000001) * 24'(SLOT_BASE));
	assign sleeping = (ctrl.sleep_state != `TTM_SLEEP_RUN);
	assign restart  = wr_i && ((addr_i == `TTM_OFS_CUR1) || (addr_i == `TTM_OFS_CUR2));
	assign end_evt  = (state == thermal_throttle_pkg::ST_RUN) && !sleeping && !restart &&
		(pos == slot_len - 24'h000001) && (slot == 8'hFF);

	// ---------------------------------------------------------------
	// Next-state logic
	// ---------------------------------------------------------------
	always_comb
	begin
		logic [8:0] sum;
		logic [7:0] r;
		sum = 9'h000;
		r = 8'h00;
		next_ctrl = ctrl;
		next_ovr = ovr;
		next_interval = interval;
		next_state = sleeping ? thermal_throttle_pkg::ST_SLEEP : thermal_throttle_pkg::ST_RUN;
		next_limit = limit;
		next_cur = cur;
		next_avg = avg;
		next_stat = stat;
		next_sub = sub;
		next_q = q;
		next_full = full;
		next_first = first;
		next_pos = pos;
		next_slot = slot;
		next_rdata = 8'h00;

		// Register writes; current readings take no value, a write only restarts.
		if (wr_i)
		begin
			if (addr_i == `TTM_OFS_CTRL)
				next_ctrl = wdata_i;
			else if (addr_i == `TTM_OFS_INTERVAL)
				next_interval = wdata_i;
			else if (addr_i == `TTM_OFS_LIMIT1)
				next_limit[0] = wdata_i;
			else if (addr_i == `TTM_OFS_LIMIT2)
				next_limit[1] = wdata_i;
			else if (addr_i == `TTM_OFS_OVERRIDE)
				next_ovr = wdata_i;
		end
		if (rd_i)
		begin
			if (addr_i == `TTM_OFS_CTRL)
				next_rdata = ctrl;
			else if (addr_i == `TTM_OFS_INTERVAL)
				next_rdata = interval;
			else if (addr_i == `TTM_OFS_LIMIT1)
				next_rdata = limit[0];
			else if (addr_i == `TTM_OFS_LIMIT2)
				next_rdata = limit[1];
			else if (addr_i == `TTM_OFS_OVERRIDE)
				next_rdata = ovr;
			else if (addr_i == `TTM_OFS_CUR1)
				next_rdata = cur[0];
			else if (addr_i == `TTM_OFS_CUR2)
				next_rdata = cur[1];
			else if (addr_i == `TTM_OFS_AVG1)
				next_rdata = avg[0];
			else if (addr_i == `TTM_OFS_AVG2)
				next_rdata = avg[1];
			else if (addr_i == `TTM_OFS_STAT1)
				next_rdata = stat[0];
			else if (addr_i == `TTM_OFS_STAT2)
				next_rdata = stat[1];
		end

		case (state)
			thermal_throttle_pkg::ST_SLEEP:
			begin
				next_pos = 24'h000000;
				next_slot = 8'h00;
				next_full = 2'h3;
				next_first = 1'b1;
				for (int i = 0; i < 2; i++)
				begin
					next_sub[i] = 24'h000000;
					next_q[i] = 9'h000;
					next_cur[i] = 8'h00;
					next_stat[i] = 8'h00;
				end
			end
			default:
			begin
				if (sleeping || restart)
				begin
					next_pos = 24'h000000;
					next_slot = 8'h00;
					next_full = 2'h3;
					for (int i = 0; i < 2; i++)
					begin
						next_sub[i] = 24'h000000;
						next_q[i] = 9'h000;
					end
				end
				else
				begin
					for (int i = 0; i < 2; i++)
					begin
						if (asserted[i])
						begin
							if ((sub[i] == 24'h000000) && (q[i] != 9'h1FF))
								next_q[i] = q[i] + 9'h001;
							next_sub[i] = (sub[i] == slot_len - 24'h000001) ?
								24'h000000 : sub[i] + 24'h000001;
						end
						else
							next_full[i] = 1'b0;
					end
					next_pos = pos + 24'h000001;
					if (pos == slot_len - 24'h000001)
					begin
						next_pos = 24'h000000;
						next_slot = slot + 8'h01;
					end
					if (end_evt)
					begin
						next_first = 1'b0;
						for (int i = 0; i < 2; i++)
						begin
							r = next_q[i][8] ? 8'hFF : next_q[i][7:0];
							next_cur[i] = r;
							sum = {1'b0, avg[i]} + {1'b0, cur[i]};
							next_avg[i] = first ? r : sum[8:1];
							next_stat[i] = band(r, next_full[i], limit[i]);
							next_sub[i] = 24'h000000;
							next_q[i] = 9'h000;
						end
						next_full = 2'h3;
					end
				end
			end
		endcase
	end

	// ---------------------------------------------------------------
	// Pin drive
	// ---------------------------------------------------------------
	always_comb
	begin
		next_pwm_pre = pwm_pre + 8'h01;
		next_pwm_ph = pwm_ph;
		if (pwm_pre == `TTM_PWM_PRESCALE)
		begin
			next_pwm_pre = 8'h00;
			next_pwm_ph = pwm_ph + 4'h1;
		end
		for (int i = 0; i < 2; i++)
		begin
			asserted[i] = !pin_s2[i];
			next_hist[i] = {hist[i][`TTM_OWN_HIST-2:0], oe[i]};
			// own drive is masked until its echo has passed the synchroniser
			ext[i] = asserted[i] && !oe[i] && (hist[i] == '0);
			hot[i] = !hot_s2[i] && !sleeping && !ctrl.hot_disable;
			ovr_on[i] = ovr.enable[i] && (pwm_ph < ovr.duty);
		end
		for (int i = 0; i < 2; i++)
		begin
			next_oe[i] = hot[i] || ovr_on[i] ||
				(ctrl.short_mode && ((|hot) || (|ovr_on) || ext[1-i]));
		end
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl <= `TTM_RST_CTRL;
			ovr <= `TTM_RST_OVERRIDE;
			interval <= `TTM_RST_INTERVAL;
			state <= thermal_throttle_pkg::ST_RUN;
			limit <= '{`TTM_RST_LIMIT, `TTM_RST_LIMIT};
			cur <= '{8'h00, 8'h00};
			avg <= '{8'h00, 8'h00};
			stat <= '{8'h00, 8'h00};
			sub <= '{24'h000000, 24'h000000};
			q <= '{9'h000, 9'h000};
			hist <= '{3'h0, 3'h0};
			full <= 2'h3;
			first <= 1'b1;
			pos <= 24'h000000;
			slot <= 8'h00;
			pwm_pre <= 8'h00;
			pwm_ph <= 4'h0;
			oe <= 2'h0;
			rdata_o <= 8'h00;
			cpu1_throttle_n_o <= 1'b0;
			cpu2_throttle_n_o <= 1'b0;
		end
		else if (ce_i)
		begin
			ctrl <= next_ctrl;
			ovr <= next_ovr;
			interval <= next_interval;
			state <= next_state;
			limit <= next_limit;
			cur <= next_cur;
			avg <= next_avg;
			stat <= next_stat;
			sub <= next_sub;
			q <= next_q;
			hist <= next_hist;
			full <= next_full;
			first <= next_first;
			pos <= next_pos;
			slot <= next_slot;
			pwm_pre <= next_pwm_pre;
			pwm_ph <= next_pwm_ph;
			oe <= next_oe;
			rdata_o <= next_rdata;
			cpu1_throttle_n_o <= 1'b0;
			cpu2_throttle_n_o <= 1'b0;
		end
	end

	assign cpu1_throttle_n_oe_o = oe[0];
	assign cpu2_throttle_n_oe_o = oe[1];

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	chk_zero_reading: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && end_evt && q[0] == 9'h000 && !asserted[0]) |=> (cur[0] == 8'h00))
		else $error("reading not zero after idle interval");
	chk_any_nonzero: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && end_evt && q[1] != 9'h000) |=> (cur[1] != 8'h00 && stat[1][6]))
		else $error("asserted interval read as zero");
	chk_avg_update: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && end_evt && !first) |=>
		(avg[0] == 8'(({1'b0, $past(avg[0])} + {1'b0, $past(cur[0])}) >> 1)))
		else $error("average not formed from previous reading");
	chk_first_copy: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && end_evt && first) |=> (avg[1] == cur[1]))
		else $error("first reading not loaded into average");
	chk_sleep_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && state == thermal_throttle_pkg::ST_SLEEP) |=>
		(cur[0] == 8'h00 && avg[0] == $past(avg[0])))
		else $error("sleep did not clear current or hold average");
	chk_full_band: assert property (@(posedge clk_i) disable iff (rst_i)
		stat[0][0] |-> !stat[0][1])
		else $error("upper band set on full throttle");
	chk_restart_both: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && restart) |=> (pos == 24'h000000 && slot == 8'h00 && q[0] == 9'h000))
		else $error("current write did not restart capture");
	chk_hot_drive: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && !regulator_hot_n_i[0] && !sleeping && !ctrl.hot_disable)[*4] |->
		cpu1_throttle_n_oe_o)
		else $error("regulator hot did not drive pin");
	chk_drive_low: assert property (@(posedge clk_i) disable iff (rst_i)
		##1 (!cpu1_throttle_n_o && !cpu2_throttle_n_o))
		else $error("throttle pin driven high");

endmodule : thermal_throttle_monitor

/* design/thermal_throttle_pkg.sv */
// Types of the thermal throttle monitor: control fields and state codes.
// Assumes thermal_throttle_map.svh is on the include path.
package thermal_throttle_pkg;

	typedef struct packed {
		logic [3:0] unused;
		logic       hot_disable;
		logic       short_mode;
		logic [1:0] sleep_state;
	} ctrl_t;

	typedef struct packed {
		logic [3:0] duty;
		logic [1:0] unused;
		logic [1:0] enable;
	} override_t;

	typedef enum logic [1:0] {
		ST_SLEEP = 2'b01,
		ST_RUN   = 2'b10
	} mon_state_t;

endpackage : thermal_throttle_pkg

/* tb/cpu_pair_model.sv */
// Behavioural model of the two processors and voltage regulators at the pins.
// Assumes pull-ups on both throttle pins and on both regulator hot lines.
`timescale 1ns/1ps

module cpu_pair_model (
	input  wire logic [1:0] dev_oe_i,
	input  wire logic [1:0] dev_val_i,
	input  wire logic [1:0] cpu_pull_i,
	input  wire logic [1:0] vr_hot_i,
	output logic      [1:0] pin_n_o,
	output logic      [1:0] hot_n_o
);
	// ---------------------------------------------------------------
	// Wire resolution
	// ---------------------------------------------------------------
	// open-drain pin level
	always_comb
	begin
		for (int i = 0; i < 2; i++)
		begin
			pin_n_o[i] = !((dev_oe_i[i] && !dev_val_i[i]) || cpu_pull_i[i]);
		end
	end

	// A released hot line floats up to its pull-up level.
	assign hot_n_o = ~vr_hot_i;
endmodule : cpu_pair_model

/* tb/thermal_throttle_monitor_test.sv */
// Self-checking bench of the thermal throttle monitor against a reference model.
// Assumes SLOT_BASE of 1 and an interval register of 1, so an interval is 512 cycles.
`timescale 1ns/1ps
`include "thermal_throttle_map.svh"

module thermal_throttle_monitor_test;
	logic                   clk_i;
	logic                   rst_i;
	logic                   ce_i;
	logic                   wr_i;
	logic                   rd_i;
	logic [`TTM_ADDR_W-1:0] addr_i;
	logic [7:0]             wdata_i;
	logic [7:0]             rdata_o;
	logic [1:0]             oe;
	logic [1:0]             val;
	logic [1:0]             pin_n;
	logic [1:0]             hot_n;
	logic [1:0]             cpu_pull;
	logic [1:0]             vr_hot;
	logic [13:0]            drv [8];
	int                     err_total;
	int                     total_checks;
	int                     cur [2];
	int                     avg [2];
	int                     lim [2];
	int                     nmeas;
	int                     n1;
	int                     n2;
	int                     duty;
	bit                     first;

	thermal_throttle_monitor #(.SLOT_BASE(1)) dut (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.cpu1_throttle_n_i(pin_n[0]), .cpu1_throttle_n_o(val[0]), .cpu1_throttle_n_oe_o(oe[0]),
		.cpu2_throttle_n_i(pin_n[1]), .cpu2_throttle_n_o(val[1]), .cpu2_throttle_n_oe_o(oe[1]),
		.regulator_hot_n_i(hot_n)
	);

	cpu_pair_model far (
		.dev_oe_i(oe), .dev_val_i(val), .cpu_pull_i(cpu_pull), .vr_hot_i(vr_hot),
		.pin_n_o(pin_n), .hot_n_o(hot_n)
	);

	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// ---------------------------------------------------------------
	// Bus and comparison tasks
	// ---------------------------------------------------------------
	task automatic chk_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_reg

	task automatic chk_cnt(input string what, input int exp, input int got);
		total_checks++;
		if (got != exp)
		begin
			err_total++;
			$display("Error %s expected %0d seen %0d", what, exp, got);
		end
	endtask : chk_cnt

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe, so sample just past that edge.
	task automatic rc(input string what, input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 chk_reg(what, exp, rdata_o);
	endtask : rc

	function automatic logic [7:0] stat_of(input int r, input bit full, input int l);
		return {r > l, r > 0, r > 0 && r < 33, r > 32 && r < 65, r > 64 && r < 129,
			r > 128 && r < 193, r > 192 && !full, full};
	endfunction : stat_of

	// A count up to 400 asserts the pin that long; above it the pin is released for
	// the remainder, so near-full readings are reached without touching the edges.
	task automatic measure(input int k1, input int k2);
		int kk [2];
		int r;
		kk[0] = k1;
		kk[1] = k2;
		cpu_pull <= {k2 > 400, k1 > 400};
		wr(4'(`TTM_OFS_CUR1 + nmeas % 2), 8'h00);
		nmeas++;
		for (int c = 0; c < 520; c++)
		begin
			@(posedge clk_i);
			for (int i = 0; i < 2; i++)
				cpu_pull[i] <= (kk[i] > 400) ^ (c >= 50 && c < 50 + (kk[i] > 400 ? 512 - kk[i] : kk[i]));
		end
		@(posedge clk_i);
		cpu_pull <= 2'b00;
		for (int i = 0; i < 2; i++)
		begin
			r = (kk[i] + 1) / 2 > 255 ? 255 : (kk[i] + 1) / 2;
			avg[i] = first ? r : (avg[i] + cur[i]) / 2;
			cur[i] = r;
			rc("current", 4'(`TTM_OFS_CUR1 + i), 8'(cur[i]));
			rc("average", 4'(`TTM_OFS_AVG1 + i), 8'(avg[i]));
			rc("status", 4'(`TTM_OFS_STAT1 + i), stat_of(r, kk[i] == 512, lim[i]));
		end
		first = 1'b0;
	endtask : measure

	task automatic print_verdict;
		$display("Checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict

	// ---------------------------------------------------------------
	// Watchdog and main sequence
	// ---------------------------------------------------------------
	initial
	begin
		#400000;
		err_total++;
		print_verdict();
	end

	initial
	begin
		ce_i = 1'b1;
		rst_i = 1'b1;
		wr_i = 1'b0;
		rd_i = 1'b0;
		addr_i = '0;
		wdata_i = 8'h00;
		cpu_pull = 2'b00;
		vr_hot = 2'b00;
		err_total = 0;
		total_checks = 0;
		nmeas = 0;
		first = 1'b1;
		drv = '{{8'h00, 6'h11}, {8'h00, 6'h22}, {8'h04, 6'h13}, {8'h04, 6'h23}, {8'h08, 6'h30},
			{8'h04, 6'h06}, {8'h04, 6'h09}, {8'h00, 6'h04}};
		void'($urandom(32'hB8C2B1ED));
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		chk_reg("drive", 8'h00, {6'h00, oe});
		rc("control", `TTM_OFS_CTRL, `TTM_RST_CTRL);
		rc("interval", `TTM_OFS_INTERVAL, `TTM_RST_INTERVAL);
		rc("limit", `TTM_OFS_LIMIT2, `TTM_RST_LIMIT);
		rc("override", `TTM_OFS_OVERRIDE, `TTM_RST_OVERRIDE);
		rc("unmapped", 4'hF, 8'h00);
		$display("reset test done");
		wr(`TTM_OFS_INTERVAL, 8'h01);
		for (int i = 0; i < 2; i++)
		begin
			lim[i] = $urandom_range(255, 0);
			wr(4'(`TTM_OFS_LIMIT1 + i), 8'(lim[i]));
			rc("limit", 4'(`TTM_OFS_LIMIT1 + i), 8'(lim[i]));
		end
		measure(1, 0);
		measure(3, 512);
		measure(64, 65);
		measure(128, 129);
		measure(256, 257);
		measure(384, 385);
		measure(510, 2);
		for (int i = 0; i < 4; i++)
			measure($urandom_range(512, 0), $urandom_range(512, 0));
		wr(`TTM_OFS_AVG1, 8'h5A);
		wr(4'hF, 8'hA5);
		rc("average", `TTM_OFS_AVG1, 8'(avg[0]));
		$display("measurement test done");
		for (int s = 1; s < 4; s++)
		begin
			wr(`TTM_OFS_CTRL, 8'(s));
			repeat (3) @(posedge clk_i);
			vr_hot <= 2'b11;
			rc("current", `TTM_OFS_CUR1, 8'h00);
			rc("current", `TTM_OFS_CUR2, 8'h00);
			rc("average", `TTM_OFS_AVG2, 8'(avg[1]));
			rc("status", `TTM_OFS_STAT1, 8'h00);
			repeat (20) @(posedge clk_i);
			chk_reg("drive", 8'h00, {6'h00, oe});
			vr_hot <= 2'b00;
		end
		cur = '{0, 0};
		wr(`TTM_OFS_CTRL, `TTM_RST_CTRL);
		first = 1'b1;
		measure(100, 200);
		measure(300, 50);
		$display("sleep test done");
		for (int i = 0; i < 8; i++)
		begin
			wr(`TTM_OFS_CTRL, drv[i][13:6]);
			vr_hot <= drv[i][5:4];
			cpu_pull <= drv[i][3:2];
			repeat (20) @(posedge clk_i);
			chk_reg("drive", {6'h00, drv[i][1:0]}, {6'h00, oe});
			chk_reg("drive value", 8'h00, {6'h00, val});
			vr_hot <= 2'b00;
			cpu_pull <= 2'b00;
			repeat (20) @(posedge clk_i);
			chk_reg("release", 8'h00, {6'h00, oe});
		end
		$display("drive test done");
		for (int sh = 0; sh < 2; sh++)
		begin
			duty = $urandom_range(15, 1);
			wr(`TTM_OFS_CTRL, sh ? 8'h04 : 8'h00);
			wr(`TTM_OFS_OVERRIDE, {4'(duty), 4'h2});
			repeat (3) @(posedge clk_i);
			n1 = 0;
			n2 = 0;
			repeat (3200)
			begin
				@(negedge clk_i);
				n1 += oe[0] === 1'b1;
				n2 += oe[1] === 1'b1;
			end
			chk_cnt("override chosen", duty * 200, n2);
			chk_cnt("override other", sh ? duty * 200 : 0, n1);
			wr(`TTM_OFS_OVERRIDE, 8'h00);
		end
		$display("override test done");
		print_verdict();
	end
endmodule : thermal_throttle_monitor_test
